// *** verilog/midi_patch_pkg.sv ***
// constants for the patch modulation engine
package midi_patch_pkg;

    // ------------------------------------------------------------
    // parameter space layout
    // ------------------------------------------------------------
    localparam int NUM_PARAMS = 128;
    localparam int MC_COUNT = 23;
    localparam int KNOB_BASE = 23;
    localparam int KNOB_LAST = 30;
    localparam int KNOB_RSV_A = 25;
    localparam int KNOB_RSV_B = 28;
    localparam int P_RESERVED = 42;
    localparam int P_KNOB_DEST = 43;
    localparam int GP_COUNT = 4;
    localparam int GP_BASE = 44;
    localparam int GP_STRIDE = 5;
    localparam int F_SRC = 0;
    localparam int F_THR = 1;
    localparam int F_DST = 2;
    localparam int F_SCL = 3;
    localparam int F_OFF = 4;
    localparam int P_ALG = 66;
    localparam int P_GL_ENABLE = 69;
    localparam int GL_BASE = 70;
    localparam int SLOT_COUNT = GP_COUNT + MC_COUNT;

    // ------------------------------------------------------------
    // sources, modes and reset values
    // ------------------------------------------------------------
    localparam int SRC_CODES = 73;
    localparam int SRC_LAST = 72;
    localparam int SRC_KNOB = 69;
    localparam logic [6:0] SRC_NONE = 7'h7F;
    localparam logic [6:0] ALG_DR = 7'h01;
    localparam logic [6:0] ALG_RESET = 7'h01;
    localparam logic [6:0] GL_OFF = 7'h00;
    localparam logic [6:0] GL_LATCH = 7'h01;
    localparam logic [6:0] GL_LIVE = 7'h02;
    localparam logic [6:0] GL_RESET = 7'h00;
    localparam int DR_NA_FIRST = 5;
    localparam int DR_NA_LAST = 10;
    localparam logic signed [7:0] OFF_MIN = -8'sh40;
    localparam logic signed [7:0] OFF_MAX = 8'sh3F;

    // ------------------------------------------------------------
    // per-algorithm upper limits of microcode parameters
    // ------------------------------------------------------------
    localparam logic [6:0] MAX_PD [0:MC_COUNT-1] = '{
        7'h7F, 7'h7F, 7'h7F, 7'h7E, 7'h7F, 7'h7E, 7'h7E, 7'h7F,
        7'h03, 7'h24, 7'h7F, 7'h0E, 7'h0F, 7'h1F, 7'h19, 7'h64,
        7'h0F, 7'h1F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F};
    localparam logic [6:0] MAX_DR [0:MC_COUNT-1] = '{
        7'h4D, 7'h7F, 7'h7F, 7'h45, 7'h7F, 7'h00, 7'h00, 7'h00,
        7'h00, 7'h00, 7'h00, 7'h0F, 7'h0F, 7'h1F, 7'h3F, 7'h64,
        7'h0F, 7'h1F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F};

endpackage : midi_patch_pkg

// *** verilog/patch_offset_calc.sv ***
// one patch offset: (source - threshold) x signed scale, shifted right by SCALE_SHIFT
`timescale 1ns/1ps
module patch_offset_calc
    import midi_patch_pkg::*;
#(
    parameter int SCALE_SHIFT = 6
) (
    // patch operands
    input wire logic active_i,
    input wire logic [6:0] src_val_i,
    input wire logic [6:0] thr_i,
    input wire logic [6:0] scale_i,
    // result
    output logic signed [7:0] offset_o
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (SCALE_SHIFT < 0 || SCALE_SHIFT > 8) begin : g_bad_shift
        $error("SCALE_SHIFT must lie in 0..8");
    end

    logic signed [7:0] diff;
    logic signed [14:0] prod;
    logic signed [14:0] shifted;

    // difference, product and saturation to the 7-bit bipolar span
    always_comb begin
        diff = $signed({1'b0, src_val_i}) - $signed({1'b0, thr_i});
        prod = diff * $signed(scale_i);
        shifted = prod >>> SCALE_SHIFT;
        if (!active_i) begin
            offset_o = 8'sh00;
        end else if (shifted > 15'(OFF_MAX)) begin
            offset_o = OFF_MAX;
        end else if (shifted < 15'(OFF_MIN)) begin
            offset_o = OFF_MIN;
        end else begin
            offset_o = shifted[7:0];
        end
    end

endmodule : patch_offset_calc

// *** verilog/midi_patch_modulation.sv ***
// patch modulation engine for the MIDI parameter space
`timescale 1ns/1ps
module midi_patch_modulation
    import midi_patch_pkg::*;
#(
    parameter int SCALE_SHIFT = 6
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // received parameter change
    input wire logic wr_valid_i,
    input wire logic [6:0] wr_num_i,
    input wire logic [6:0] wr_data_i,
    // transmit request
    input wire logic rd_req_i,
    input wire logic [6:0] rd_num_i,
    // controller updates
    input wire logic ctl_valid_i,
    input wire logic [6:0] ctl_code_i,
    input wire logic [6:0] ctl_val_i,
    // front panel knob and setup recall
    input wire logic knob_valid_i,
    input wire logic [6:0] knob_val_i,
    input wire logic recall_i,
    // transmit answer
    output logic rd_valid_o,
    output logic [6:0] rd_data_o,
    // effective values for the audio processor
    output logic [4:0] eff_num_o,
    output logic [6:0] eff_data_o
);

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [6:0] pmem [0:NUM_PARAMS-1];
    logic [6:0] src_val [0:SRC_CODES-1];
    logic signed [7:0] off_gp [0:GP_COUNT-1];
    logic signed [7:0] off_gl [0:MC_COUNT-1];
    logic [MC_COUNT-1:0] gl_arm;
    logic [4:0] slot;
    logic [4:0] out_idx;
    logic [6:0] rd_num_q;
    logic [6:0] eff_val [0:MC_COUNT-1];
    logic is_dr;
    logic [6:0] gl_mode;
    assign is_dr = (pmem[P_ALG] == ALG_DR);
    assign gl_mode = pmem[P_GL_ENABLE];
    // upper limit of a microcode param for the active algorithm
    function automatic logic [6:0] mc_max(input logic dr, input logic [4:0] p);
        return dr ? MAX_DR[p] : MAX_PD[p];
    endfunction : mc_max
    // whether a microcode param exists in the active algorithm
    function automatic logic mc_avail(input logic dr, input logic [4:0] p);
        return !(dr && p >= 5'(DR_NA_FIRST) && p <= 5'(DR_NA_LAST));
    endfunction : mc_avail
    // ------------------------------------------------------------
    // sweep over the patch slots
    // ------------------------------------------------------------
    logic [1:0] gp_i;
    logic [6:0] gp_addr;
    logic [6:0] gp_code;
    logic [6:0] gp_dst;
    logic gp_active;
    logic [6:0] gp_src;
    logic signed [7:0] calc_off;
    logic [4:0] gl_k;
    logic [6:0] gl_code;
    logic gl_use;
    logic [6:0] gl_src;
    // operand fetch for the current slot
    always_comb begin
        gp_i = slot[1:0];
        gp_addr = 7'(GP_BASE + GP_STRIDE * int'(gp_i));
        gp_code = pmem[gp_addr + 7'(F_SRC)];
        gp_dst = pmem[gp_addr + 7'(F_DST)];
        gp_active = (gp_code <= 7'(SRC_LAST)) && (gp_dst < 7'(MC_COUNT));
        gp_src = (gp_code <= 7'(SRC_LAST)) ? src_val[gp_code] : 7'h00;
        gl_k = (slot >= 5'(GP_COUNT)) ? slot - 5'(GP_COUNT) : 5'h00;
        gl_code = pmem[7'(GL_BASE) + {2'b00, gl_k}];
        gl_use = (gl_mode == GL_LIVE) || (gl_mode == GL_LATCH && gl_arm[gl_k]);
        gl_src = (gl_code <= 7'(SRC_LAST) && gl_use) ? src_val[gl_code] : 7'h00;
    end
    patch_offset_calc #(
        .SCALE_SHIFT(SCALE_SHIFT)
    ) patch_offset_calc_inst (
        .active_i(gp_active),
        .src_val_i(gp_src),
        .thr_i(pmem[gp_addr + 7'(F_THR)]),
        .scale_i(pmem[gp_addr + 7'(F_SCL)]),
        .offset_o(calc_off)
    );
    // slot counter, one slot per clock
    always_ff @(posedge clock_i) begin
        if (rst_i || slot == 5'(SLOT_COUNT - 1)) begin
            slot <= 5'h00;
        end else begin
            slot <= slot + 5'h01;
        end
    end
    // offset registers: sweep result overwrites any external write
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < GP_COUNT; i++) off_gp[i] <= 8'sh00;
            for (int k = 0; k < MC_COUNT; k++) off_gl[k] <= 8'sh00;
        end else begin
            for (int i = 0; i < GP_COUNT; i++) begin
                if (wr_valid_i && wr_num_i == 7'(GP_BASE + GP_STRIDE * i + F_OFF)) begin
                    off_gp[i] <= {wr_data_i[6], wr_data_i};
                end
            end
            if (slot < 5'(GP_COUNT)) begin
                off_gp[gp_i] <= calc_off;
            end else begin
                off_gl[gl_k] <= $signed({1'b0, gl_src});
            end
        end
    end
    // global patches: latch mode waits for the source to move
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gl_arm <= '0;
        end else begin
            for (int k = 0; k < MC_COUNT; k++) begin
                gl_arm[k] <= (gl_arm[k] && !recall_i)
                    || (ctl_valid_i && ctl_code_i == pmem[GL_BASE + k])
                    || (knob_valid_i && pmem[GL_BASE + k] == 7'(SRC_KNOB));
            end
        end
    end

    // ------------------------------------------------------------
    // effective values: base plus offsets, saturated
    // ------------------------------------------------------------
    for (genvar p = 0; p < MC_COUNT; p++) begin : g_eff
        logic signed [10:0] sum;
        always_comb begin
            sum = $signed({4'h0, pmem[p]}) + 11'(off_gl[p]);
            for (int i = 0; i < GP_COUNT; i++) begin
                if (pmem[GP_BASE + GP_STRIDE * i + F_DST] == 7'(p)) begin
                    sum = sum + 11'(off_gp[i]);
                end
            end
            if (!mc_avail(is_dr, 5'(p)) || sum < 11'sh000) begin
                eff_val[p] = 7'h00;
            end else if (sum > $signed({4'h0, mc_max(is_dr, 5'(p))})) begin
                eff_val[p] = mc_max(is_dr, 5'(p));
            end else begin
                eff_val[p] = sum[6:0];
            end
        end
    end
    // ------------------------------------------------------------
    // base value write path
    // ------------------------------------------------------------
    logic next_we;
    logic [6:0] next_addr;
    logic [6:0] next_data;
    logic [6:0] knob_dst;
    logic [4:0] tgt;
    // decode a received change or a knob turn into one base write
    always_comb begin
        next_we = 1'b0;
        next_addr = wr_num_i;
        next_data = wr_data_i;
        knob_dst = pmem[P_KNOB_DEST];
        tgt = 5'h00;
        if (wr_valid_i) begin
            if (wr_num_i < 7'(MC_COUNT)) begin
                tgt = wr_num_i[4:0];
                next_we = mc_avail(is_dr, tgt);
            end else if (wr_num_i <= 7'(KNOB_LAST)) begin
                tgt = 5'(wr_num_i - 7'(KNOB_BASE));
                next_we = wr_num_i != 7'(KNOB_RSV_A) && wr_num_i != 7'(KNOB_RSV_B)
                    && mc_avail(is_dr, tgt);
                next_addr = {2'b00, tgt};
            end else begin
                next_we = wr_num_i != 7'(P_RESERVED)
                    && !(wr_num_i >= 7'(GP_BASE) && wr_num_i < 7'(GL_BASE - 1)
                    && (wr_num_i - 7'(GP_BASE)) % 7'(GP_STRIDE) == 7'(F_OFF));
            end
        end else if (knob_valid_i && knob_dst < 7'(MC_COUNT)) begin
            tgt = knob_dst[4:0];
            next_we = mc_avail(is_dr, tgt);
            next_addr = knob_dst;
            next_data = knob_val_i;
        end
        if (next_addr < 7'(MC_COUNT) && next_data > mc_max(is_dr, tgt)) begin
            next_data = mc_max(is_dr, tgt);
        end
    end
    // parameter store
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int a = 0; a < NUM_PARAMS; a++) begin
                if (a == P_ALG) begin
                    pmem[a] <= ALG_RESET;
                end else if (a == P_GL_ENABLE) begin
                    pmem[a] <= GL_RESET;
                end else if (a >= GL_BASE || (a >= GP_BASE && a < GL_BASE - 1
                        && (a - GP_BASE) % GP_STRIDE == F_SRC)) begin
                    pmem[a] <= SRC_NONE;
                end else begin
                    pmem[a] <= 7'h00;
                end
            end
        end else if (next_we) begin
            pmem[next_addr] <= next_data;
        end
    end
    // controller source values
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int c = 0; c < SRC_CODES; c++) src_val[c] <= 7'h00;
        end else begin
            if (ctl_valid_i && ctl_code_i <= 7'(SRC_LAST)) begin
                src_val[ctl_code_i] <= ctl_val_i;
            end
            if (knob_valid_i) begin
                src_val[SRC_KNOB] <= knob_val_i;
            end
        end
    end
    // ------------------------------------------------------------
    // transmit answer and audio value stream
    // ------------------------------------------------------------
    logic [6:0] rd_val;
    logic [6:0] rd_rel;
    // value sent for a requested parameter
    always_comb begin
        rd_rel = rd_num_i - 7'(GP_BASE);
        rd_val = pmem[rd_num_i];
        if (rd_num_i < 7'(MC_COUNT)) begin
            rd_val = eff_val[rd_num_i[4:0]];
        end else if (rd_num_i <= 7'(KNOB_LAST)) begin
            if (rd_num_i == 7'(KNOB_RSV_A) || rd_num_i == 7'(KNOB_RSV_B)) begin
                rd_val = 7'h00;
            end else begin
                rd_val = eff_val[5'(rd_num_i - 7'(KNOB_BASE))];
            end
        end else if (rd_num_i == 7'(P_RESERVED)) begin
            rd_val = 7'h00;
        end else if (rd_num_i >= 7'(GP_BASE) && rd_num_i < 7'(GL_BASE - 1)
                && rd_rel % 7'(GP_STRIDE) == 7'(F_OFF)) begin
            rd_val = off_gp[2'(rd_rel / 7'(GP_STRIDE))][6:0];
        end
    end
    // one-cycle answer to each request
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 7'h00;
            rd_num_q <= 7'h00;
        end else begin
            rd_valid_o <= rd_req_i;
            rd_num_q <= rd_num_i;
            if (rd_req_i) begin
                rd_data_o <= rd_val;
            end
        end
    end
    // round-robin feed of effective values to the audio side
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_idx <= 5'h00;
            eff_num_o <= 5'h00;
            eff_data_o <= 7'h00;
        end else begin
            out_idx <= (out_idx == 5'(MC_COUNT - 1)) ? 5'h00 : out_idx + 5'h01;
            eff_num_o <= out_idx;
            eff_data_o <= eff_val[out_idx];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_stream_end;
        eff_num_o == 5'(MC_COUNT - 1);
    endsequence
    sequence s_stream_wrap;
        eff_num_o == 5'h00 ##22 eff_num_o == 5'(MC_COUNT - 1);
    endsequence
    AST_BASE_STORE: assert property (
        (wr_valid_i && wr_num_i == 7'h0B && wr_data_i <= mc_max(is_dr, 5'h0B))
        |=> pmem[11] == $past(wr_data_i))
        else $error("received value not stored as base");
    AST_RD_ANSWER: assert property (
        rd_req_i |=> rd_valid_o && rd_data_o == $past(rd_val))
        else $error("transmit answer missing or wrong");
    AST_RD_RANGE: assert property (
        (rd_valid_o && rd_num_q < 7'(MC_COUNT) && $stable(is_dr))
        |-> rd_data_o <= mc_max(is_dr, rd_num_q[4:0]))
        else $error("transmitted value out of range");
    AST_NA_ZERO: assert property (
        (rd_valid_o && is_dr && rd_num_q >= 7'h05 && rd_num_q <= 7'h0A && $stable(is_dr))
        |-> rd_data_o == 7'h00)
        else $error("unavailable parameter not zero");
    AST_SWEEP_WRAP: assert property (
        slot == 5'(SLOT_COUNT - 1) |=> slot == 5'h00 ##4 slot == 5'h04)
        else $error("patch sweep does not wrap");
    AST_GL_DISABLED: assert property (
        (slot == 5'h05 && gl_mode == GL_OFF) |=> off_gl[1] == 8'sh00)
        else $error("global patch active while disabled");
    AST_EFF_STREAM: assert property (
        s_stream_end |=> s_stream_wrap)
        else $error("effective value stream out of order");
    AST_KNOB_SRC: assert property (
        knob_valid_i |=> src_val[SRC_KNOB] == $past(knob_val_i))
        else $error("knob source not captured");
    AST_GP_OFFSET: assert property (
        slot == 5'h00 |=> off_gp[0] == $past(calc_off) && off_gp[0] <= OFF_MAX)
        else $error("patch offset not refreshed");
endmodule : midi_patch_modulation

// *** test/midi_ctl_model.sv ***
// far-side controller model: parameter changes, requests, controller and panel events
`timescale 1ns/1ps
module midi_ctl_model (
    // clock
    input wire logic clock_i,
    // parameter messages
    output logic wr_valid_o,
    output logic [6:0] wr_num_o,
    output logic [6:0] wr_data_o,
    output logic rd_req_o,
    output logic [6:0] rd_num_o,
    // controller and panel events
    output logic ctl_valid_o,
    output logic [6:0] ctl_code_o,
    output logic [6:0] ctl_val_o,
    output logic knob_valid_o,
    output logic [6:0] knob_val_o,
    output logic recall_o
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        {wr_valid_o, rd_req_o, ctl_valid_o, knob_valid_o, recall_o} = 5'h00;
        {wr_num_o, wr_data_o, rd_num_o} = 21'h0_0000;
        {ctl_code_o, ctl_val_o, knob_val_o} = 21'h0_0000;
    end

    // ------------------------------------------------------------
    // message tasks: one-cycle strobes, then scrambled idle data
    // ------------------------------------------------------------
    // words are raw 7-bit codes; scale and bipolar words stay two's complement
    task automatic send_param(input logic [6:0] num, input logic [6:0] val);
        @(posedge clock_i);
        wr_valid_o <= 1'b1;
        wr_num_o <= num;
        wr_data_o <= val;
        @(posedge clock_i);
        wr_valid_o <= 1'b0;
        wr_num_o <= ~num;
        wr_data_o <= ~val;
    endtask : send_param

    task automatic request(input logic [6:0] num);
        @(posedge clock_i);
        rd_req_o <= 1'b1;
        rd_num_o <= num;
        @(posedge clock_i);
        rd_req_o <= 1'b0;
        rd_num_o <= ~num;
    endtask : request

    task automatic move_ctl(input logic [6:0] code, input logic [6:0] val);
        @(posedge clock_i);
        ctl_valid_o <= 1'b1;
        ctl_code_o <= code;
        ctl_val_o <= val;
        @(posedge clock_i);
        ctl_valid_o <= 1'b0;
        ctl_val_o <= ~val;
    endtask : move_ctl

    task automatic move_knob(input logic [6:0] val);
        @(posedge clock_i);
        knob_valid_o <= 1'b1;
        knob_val_o <= val;
        @(posedge clock_i);
        knob_valid_o <= 1'b0;
        knob_val_o <= ~val;
    endtask : move_knob

    task automatic recall;
        @(posedge clock_i);
        recall_o <= 1'b1;
        @(posedge clock_i);
        recall_o <= 1'b0;
    endtask : recall
endmodule : midi_ctl_model

// *** test/midi_patch_modulation_tb.sv ***
// self-checking bench for the patch modulation engine
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
    comparisons++; \
    if ((gt) !== (ex)) begin \
        $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
        err_count++; \
    end \
end
module midi_patch_modulation_tb;
    import midi_patch_pkg::*;
    logic clock_i, rst_i, wr_valid_i, rd_req_i, ctl_valid_i, knob_valid_i, recall_i;
    logic [6:0] wr_num_i, wr_data_i, rd_num_i, ctl_code_i, ctl_val_i, knob_val_i;
    logic rd_valid_o;
    logic [6:0] rd_data_o, eff_data_o, got_exp, got_num;
    logic [4:0] eff_num_o;
    logic [6:0] exp_q[$];
    logic [6:0] num_q[$];
    int err_count = 0;
    int comparisons = 0;
    integer seed;

    // ------------------------------------------------------------
    // design and far-side model
    // ------------------------------------------------------------
    midi_patch_modulation #(.SCALE_SHIFT(0)) midi_patch_modulation_inst (
        .clock_i(clock_i), .rst_i(rst_i),
        .wr_valid_i(wr_valid_i), .wr_num_i(wr_num_i), .wr_data_i(wr_data_i),
        .rd_req_i(rd_req_i), .rd_num_i(rd_num_i),
        .ctl_valid_i(ctl_valid_i), .ctl_code_i(ctl_code_i), .ctl_val_i(ctl_val_i),
        .knob_valid_i(knob_valid_i), .knob_val_i(knob_val_i), .recall_i(recall_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .eff_num_o(eff_num_o), .eff_data_o(eff_data_o));
    midi_ctl_model midi_ctl_model_inst (
        .clock_i(clock_i),
        .wr_valid_o(wr_valid_i), .wr_num_o(wr_num_i), .wr_data_o(wr_data_i),
        .rd_req_o(rd_req_i), .rd_num_o(rd_num_i),
        .ctl_valid_o(ctl_valid_i), .ctl_code_o(ctl_code_i), .ctl_val_o(ctl_val_i),
        .knob_valid_o(knob_valid_i), .knob_val_o(knob_val_i), .recall_o(recall_i));

    // ------------------------------------------------------------
    // clock, helpers and verdict
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic conclude;
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic wp(input logic [6:0] n, input logic [6:0] v);
        midi_ctl_model_inst.send_param(n, v);
    endtask : wp

    task automatic cm(input logic [6:0] c, input logic [6:0] v);
        midi_ctl_model_inst.move_ctl(c, v);
    endtask : cm

    // sweep of 27 slots plus five cycles for the offset to land
    task automatic settle;
        repeat (32) @(posedge clock_i);
    endtask : settle

    // note the expected answer, then send the request
    task automatic rd_chk(input logic [6:0] num, input logic [6:0] ex);
        exp_q.push_back(ex);
        num_q.push_back(num);
        midi_ctl_model_inst.request(num);
    endtask : rd_chk

    // catch the audio stream at one index
    task automatic eff_chk(input logic [4:0] idx, input logic [6:0] ex);
        int n;
        for (n = 0; n < 40; n++) begin
            @(negedge clock_i);
            if (eff_num_o === idx) break;
        end
        if (n == 40) begin
            err_count++;
            conclude();
        end else begin
            `CHK("eff_data_o", ex, eff_data_o)
        end
    endtask : eff_chk

    // answer watcher: oldest note against each valid answer
    always @(posedge clock_i) begin
        if (rd_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("rd_valid_o", 1'b0, rd_valid_o)
            end else begin
                got_exp = exp_q.pop_front();
                got_num = num_q.pop_front();
                `CHK($sformatf("rd_data_o[%0d]", got_num), got_exp, rd_data_o)
            end
        end
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int p;
        int n;
        logic [6:0] b, v, c;
        seed = 32'hd797_0b88;
        rst_i = 1'b1;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        // reset contents and write clamping
        rd_chk(7'h42, ALG_RESET);
        rd_chk(7'h45, GL_RESET);
        rd_chk(7'h3B, SRC_NONE);
        wp(7'h00, 7'h64);
        rd_chk(7'h00, 7'h4D);
        rd_chk(7'h17, 7'h4D);
        rd_chk(7'h19, 7'h00);
        // patch 1: cc0 minus 10, times scale, onto param 11 (base 5)
        wp(7'h2D, 7'h0A);
        wp(7'h2E, 7'h0B);
        wp(7'h2F, 7'h03);
        wp(7'h0B, 7'h05);
        wp(7'h2C, 7'h00);
        cm(7'h00, 7'h0C);
        settle();
        rd_chk(7'h30, 7'h06);
        rd_chk(7'h0B, 7'h0B);
        eff_chk(5'h0B, 7'h0B);
        wp(7'h30, 7'h20);
        settle();
        rd_chk(7'h30, 7'h06);
        wp(7'h2F, 7'h7E);
        settle();
        rd_chk(7'h30, 7'h7C);
        rd_chk(7'h0B, 7'h01);
        wp(7'h2F, 7'h40);
        settle();
        rd_chk(7'h30, 7'h40);
        rd_chk(7'h0B, 7'h00);
        wp(7'h2F, 7'h03);
        wp(7'h2C, 7'h40);
        cm(7'h40, 7'h1E);
        settle();
        rd_chk(7'h30, 7'h3C);
        rd_chk(7'h0B, 7'h0F);
        wp(7'h2E, 7'h17);
        settle();
        rd_chk(7'h0B, 7'h05);
        rd_chk(7'h30, 7'h00);
        // all four patches, controller and switch sources, unity gain
        for (p = 0; p < 4; p++) begin
            b = 7'(44 + 5 * p);
            v = 7'($random(seed)) & 7'h07;
            c = (p % 2 == 1) ? 7'(32 + p) : 7'(p);
            wp(7'(b + 1), 7'h00);
            wp(7'(b + 2), 7'(12 + p));
            wp(7'(b + 3), 7'h01);
            wp(b, c);
            cm(c, v);
            settle();
            rd_chk(7'(b + 4), v);
            rd_chk(7'(12 + p), v);
        end
        // global patch 90 (aftertouch) onto param 20, through each enable mode
        wp(7'h5A, 7'h42);
        cm(7'h42, 7'h09);
        settle();
        rd_chk(7'h14, 7'h00);
        wp(7'h45, GL_LIVE);
        settle();
        rd_chk(7'h14, 7'h09);
        eff_chk(5'h14, 7'h09);
        wp(7'h45, GL_LATCH);
        midi_ctl_model_inst.recall();
        settle();
        rd_chk(7'h14, 7'h00);
        cm(7'h42, 7'h09);
        settle();
        rd_chk(7'h14, 7'h09);
        // knob writes the param named by 43
        wp(7'h2B, 7'h15);
        midi_ctl_model_inst.move_knob(7'h28);
        rd_chk(7'h15, 7'h28);
        // params 5..10 exist only outside delay/reverb
        wp(7'h05, 7'h0A);
        rd_chk(7'h05, 7'h00);
        wp(7'h42, 7'h02);
        wp(7'h05, 7'h0A);
        rd_chk(7'h05, 7'h0A);
        wp(7'h42, ALG_DR);
        rd_chk(7'h05, 7'h00);
        for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clock_i);
        if (exp_q.size() != 0) err_count++;
        conclude();
    end
endmodule : midi_patch_modulation_tb
